// >>> hdl/svd_defines.vh
// Offsets, field positions, reset values and timing counts of the supply detect block
// How it works
// [RULE1] Enable bit 0 of control register starts monitoring; resets to zero, monitoring off.
// [RULE2] While enabled, both flags follow comparator outputs every clock cycle.
// [RULE3] Flags count as valid only 20 us after enable is set.
// [RULE4] Upper threshold flag at bit 2 reads one only while supply is below it.
// [RULE5] Low battery flag is read only, one on low condition, zero after reset.
// [RULE6] Enabled and low battery flag set drives low voltage request line five.
// [RULE7] Request bit 5 latches the low event until software clears it or reset.
// [RULE8] Latched request interrupts only when its mask bit is set, else poll only.
// [RULE9] No detection, flag update or request while in the stop low-power state.
// [RULE10] Software writes zeros to reserved upper bits of the control register.
// [RULE11] Software avoids reprogramming port zero one mode while checking low voltage.
// [RULE12] Software enables interrupts globally before setting the detection enable bit.
// [RULE13] Each comparator output passes two flip-flops before flags or request.
`ifndef SVD_DEFINES_VH
`define SVD_DEFINES_VH
`define SVD_CTRL_OFS        8'h0c
`define SVD_IRQ_OFS         8'h10
`define SVD_IMR_OFS         8'h14
`define SVD_EN_BIT          0
`define SVD_LOW_BIT         1
`define SVD_UPPER_BIT       2
`define SVD_REQ_BIT         5
`define SVD_CTRL_RESET      8'h00
`define SVD_IRQ_RESET       8'h00
`define SVD_IMR_RESET       8'h00
`define SVD_SETTLE_NS       20000
`define SVD_CLK_MHZ         20
`define SVD_SETTLE_CYCLES   ((`SVD_SETTLE_NS * `SVD_CLK_MHZ) / 1000)
`endif

// >>> hdl/svd_supply_detect.v
// Supply voltage detect flags with AXI4-Lite register access
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "svd_defines.vh"
module svd_supply_detect #(
   parameter integer SETTLE_CYCLES = `SVD_SETTLE_CYCLES
) (
   input  wire        clk,
   input  wire        reset,
   input  wire        low_cmp,
   input  wire        upper_cmp,
   input  wire        stop_mode,
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   output reg         flags_valid_q,
   output reg         low_voltage_request_line,
   output reg         irq_q
);
   localparam [1:0] RESP_OKAY   = 2'b00;
   localparam [1:0] RESP_SLVERR = 2'b10;
   localparam integer CW = 16;

   // Synchronisers; stage one feeds only stage two
   reg [1:0] low_s1_q;
   reg [1:0] low_s2_q;
   reg       stop_s1_q;
   reg       stop_s2_q;

   reg        voltage_monitor_enable_q;
   reg        low_battery_flag_q;
   reg        upper_threshold_flag_q;
   reg [7:0]  irq_status_q;
   reg [7:0]  interrupt_mask_register_q;
   reg [CW-1:0] settle_cnt_q;

   reg        aw_held_q;
   reg [7:0]  aw_addr_q;
   reg        w_held_q;
   reg [31:0] w_data_q;
   reg [3:0]  w_strb_q;

   wire       active = voltage_monitor_enable_q & ~stop_s2_q; // [RULE9]
   wire       wr_go  = aw_held_q & w_held_q & ~s_axi_bvalid;
   reg        wr_ctrl;
   reg        wr_irq;
   reg        wr_imr;
   reg        wr_hit;

   // Write decode; a cleared byte 0 strobe to a mapped register turns the write into a no-op with an OKAY answer
   always @* begin
      wr_ctrl = 1'b0;
      wr_irq  = 1'b0;
      wr_imr  = 1'b0;
      wr_hit  = 1'b1;
      if (aw_addr_q == `SVD_CTRL_OFS) begin
         wr_ctrl = wr_go & w_strb_q[0];
      end else if (aw_addr_q == `SVD_IRQ_OFS) begin
         wr_irq = wr_go & w_strb_q[0];
      end else if (aw_addr_q == `SVD_IMR_OFS) begin
         wr_imr = wr_go & w_strb_q[0];
      end else begin
         wr_hit = 1'b0;
      end
   end

   wire       low_evt = active & low_s2_q[0]; // [RULE6]
   wire [7:0] ctrl_rd = {5'h00, upper_threshold_flag_q, low_battery_flag_q,
                         voltage_monitor_enable_q};
   reg  [7:0] irq_status_d;

   always @* begin
      irq_status_d = irq_status_q;
      if (wr_irq) begin
         irq_status_d = irq_status_q & ~w_data_q[7:0];
      end
      // Set wins over a clear in the same cycle
      if (low_evt) begin
         irq_status_d[`SVD_REQ_BIT] = 1'b1; // [RULE7]
      end
   end

   always @(posedge clk) begin
      if (reset) begin
         low_s1_q <= 2'b00;
         low_s2_q <= 2'b00;
         stop_s1_q <= 1'b0;
         stop_s2_q <= 1'b0;
      end else begin
         low_s1_q <= {upper_cmp, low_cmp}; // [RULE13]
         low_s2_q <= low_s1_q;
         stop_s1_q <= stop_mode;
         stop_s2_q <= stop_s1_q;
      end
   end

   always @(posedge clk) begin
      if (reset) begin
         voltage_monitor_enable_q <= 1'b0; // [RULE1]
         low_battery_flag_q <= 1'b0; // [RULE5]
         upper_threshold_flag_q <= 1'b0; // [RULE4]
         irq_status_q <= `SVD_IRQ_RESET;
         interrupt_mask_register_q <= `SVD_IMR_RESET;
         settle_cnt_q <= {CW{1'b0}};
         flags_valid_q <= 1'b0;
         low_voltage_request_line <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            // Reserved and read-only bits ignore writes
            voltage_monitor_enable_q <= w_data_q[`SVD_EN_BIT]; // [RULE1]
         end
         if (wr_imr) begin
            interrupt_mask_register_q <= w_data_q[7:0];
         end
         // Flags freeze in stop state; the comparators are off then
         if (active) begin
            low_battery_flag_q <= low_s2_q[0]; // [RULE2] [RULE5]
            upper_threshold_flag_q <= low_s2_q[1]; // [RULE2] [RULE4]
         end else if (!voltage_monitor_enable_q) begin
            low_battery_flag_q <= 1'b0;
            upper_threshold_flag_q <= 1'b0;
         end
         if (!voltage_monitor_enable_q) begin
            settle_cnt_q <= {CW{1'b0}};
            flags_valid_q <= 1'b0;
         end else if (settle_cnt_q >= SETTLE_CYCLES[CW-1:0]) begin
            flags_valid_q <= 1'b1; // [RULE3]
         end else begin
            settle_cnt_q <= settle_cnt_q + {{(CW-1){1'b0}}, 1'b1};
         end
         irq_status_q <= irq_status_d;
         low_voltage_request_line <= low_evt; // [RULE6]
         irq_q <= |(irq_status_d & interrupt_mask_register_q); // [RULE8]
      end
   end

   // Write channel: address and data taken in either order
   always @(posedge clk) begin
      if (reset) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h00000000;
         w_strb_q <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         s_axi_awready <= ~aw_held_q & ~s_axi_awready & s_axi_awvalid;
         s_axi_wready <= ~w_held_q & ~s_axi_wready & s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (wr_hit) begin
               s_axi_bresp <= RESP_OKAY;
            end else begin
               s_axi_bresp <= RESP_SLVERR;
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Read channel
   always @(posedge clk) begin
      if (reset) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            if ({s_axi_araddr[7:2], 2'b00} == `SVD_CTRL_OFS) begin
               s_axi_rdata <= {24'h000000, ctrl_rd};
            end else if ({s_axi_araddr[7:2], 2'b00} == `SVD_IRQ_OFS) begin
               s_axi_rdata <= {24'h000000, irq_status_q};
            end else if ({s_axi_araddr[7:2], 2'b00} == `SVD_IMR_OFS) begin
               s_axi_rdata <= {24'h000000, interrupt_mask_register_q};
            end else begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= RESP_SLVERR;
            end
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// >>> bench/svd_cmp_model.sv
// Behavioural model of the two analog supply comparators
`timescale 1ns/1ps
`default_nettype none
module svd_cmp_model (
   input  wire logic       clk,
   input  wire logic [1:0] level,
   output var  logic       low_cmp,
   output var  logic       upper_cmp
);
   // One cycle of settling, so the design never sees a change on the edge it was made
   always @(posedge clk) {upper_cmp, low_cmp} <= level;
endmodule
`default_nettype wire

// >>> bench/svd_props_properties.sv
// Port assertions for the supply detect block
`timescale 1ns/1ps
`default_nettype none
module svd_props #(
   parameter integer SETTLE_CYCLES = 8
) (
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        low_cmp,
   input wire logic        stop_mode,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        flags_valid_q,
   input wire logic        low_voltage_request_line,
   input wire logic        irq_q
);
   logic [15:0] since_wr_q;
   always @(posedge clk) begin
      if (reset | (s_axi_wvalid & s_axi_wready)) begin
         since_wr_q <= 16'h0000;
      end else begin
         since_wr_q <= since_wr_q + 16'h0001;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   sequence s_wr_recent;
      $past(s_axi_wvalid) || $past(s_axi_wvalid, 2) || $past(s_axi_wvalid, 3);
   endsequence
   sequence s_stopped;
      stop_mode [*4];
   endsequence
   chk_req_cause: assert property (low_voltage_request_line |-> $past(low_cmp, 3))
      else $error("request without low comparator");
   chk_stop_quiet: assert property (s_stopped |-> !$rose(low_voltage_request_line) && !$rose(irq_q))
      else $error("request during stop");
   chk_irq_clear: assert property ($fell(irq_q) |-> s_wr_recent)
      else $error("irq dropped without write");
   chk_enable_drop: assert property ($fell(flags_valid_q) |-> s_wr_recent)
      else $error("flags valid dropped without write");
   chk_settle_time: assert property ($rose(flags_valid_q) |-> since_wr_q >= SETTLE_CYCLES - 1)
      else $error("flags valid too early");
   chk_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
   chk_wr_answer: assert property (s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
      else $error("write answer late");
endmodule
bind svd_supply_detect svd_props #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_props (.*);
`default_nettype wire

// >>> bench/tb_top.sv
// Self-checking bench for the supply detect block
`timescale 1ns/1ps
`default_nettype none
`include "svd_defines.vh"
module tb_top;
   localparam integer SETTLE_CYCLES = 8;
   logic clk = 0, reset = 1, stop_mode = 0, low_cmp, upper_cmp, ta, tv, tb;
   logic [1:0] level = 0, s_axi_bresp, s_axi_rresp;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, seed = 32'h0b6d62af;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, flags_valid_q, low_voltage_request_line, irq_q;
   int num_errors = 0, cmp_count = 0, i, n;
   svd_supply_detect #(.SETTLE_CYCLES(SETTLE_CYCLES)) dut (.*);
   svd_cmp_model u_cmp (.clk(clk), .level(level), .low_cmp(low_cmp), .upper_cmp(upper_cmp));
   always #25 clk = ~clk;
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      return s ^ (s << 5);
   endfunction
   function automatic logic [31:0] ctrl_exp(input logic [1:0] lv, input logic en);
      return {29'h0, lv & {2{en}}, en};
   endfunction
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wrap_up;
      $display("%0d checks, %0d mismatches", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Write when w is set, else read and compare data and response
   task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] v,
                      input string nm = "", input logic [1:0] er = 2'h0);
      n = 0;
      seed = xs(seed);
      @(posedge clk);
      if (w) {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, v, 3'h7};
      else {s_axi_araddr, s_axi_arvalid} <= {a, 1'b1};
      do begin
         @(negedge clk);
         ta = s_axi_awready | s_axi_arready;
         tv = w ? s_axi_wready : s_axi_rvalid;
         tb = w ? s_axi_bvalid : s_axi_rvalid & s_axi_rready;
         if (tb & !w) chk(nm, s_axi_rdata, v);
         if (tb & !w) chk(nm, s_axi_rresp, er);
         if (tb & w) chk("write response", s_axi_bresp, er);
         @(posedge clk);
         if (ta) {s_axi_awvalid, s_axi_arvalid} <= 2'h0;
         if (tv & w) s_axi_wvalid <= 0;
         // Random late ready leaves read data waiting on the bus
         if (!w) s_axi_rready <= !tb & (tv | seed[0]);
         n++;
      end while (!tb && n < 40);
      s_axi_bready <= 0;
      if (n >= 40) begin
         num_errors++;
         wrap_up();
      end
   endtask
   initial begin
      repeat (3) @(posedge clk);
      reset <= 0;
      bus(0, `SVD_CTRL_OFS, 0, "control");
      bus(0, `SVD_IRQ_OFS, 0, "status");
      bus(0, `SVD_IMR_OFS, 0, "mask");
      bus(0, 8'h20, 0, "unmapped", 2'h2);
      bus(1, 8'h20, 32'h1, "unmapped write", 2'h2);
      bus(1, `SVD_IMR_OFS, 32'h20);
      level <= 2'b10;
      bus(1, `SVD_CTRL_OFS, 32'h1);
      repeat (SETTLE_CYCLES) @(negedge clk);
      chk("settle early", flags_valid_q, 0);
      @(negedge clk);
      chk("settle", flags_valid_q, 1);
      $display("reset and settle test done");
      // Port mode is left alone while monitoring, so no switching noise reaches the flags
      for (i = 0; i < 10; i++) begin
         @(posedge clk);
         seed = xs(seed);
         level <= (i == 0) ? 2'b11 : seed[2:1];
         repeat (6) @(posedge clk);
         bus(0, `SVD_CTRL_OFS, ctrl_exp(level, 1), "flags");
         @(negedge clk);
         chk("request", low_voltage_request_line, level[0]);
      end
      level <= 2'b00;
      repeat (6) @(posedge clk);
      bus(0, `SVD_IRQ_OFS, 32'h20, "latched");
      @(negedge clk);
      chk("irq", irq_q, 1);
      bus(1, `SVD_IMR_OFS, 0);
      @(negedge clk);
      chk("irq masked", irq_q, 0);
      bus(0, `SVD_IRQ_OFS, 32'h20, "polled");
      bus(1, `SVD_IRQ_OFS, 32'h20);
      bus(0, `SVD_IRQ_OFS, 0, "cleared");
      $display("random and interrupt test done");
      stop_mode <= 1;
      repeat (4) @(posedge clk);
      level <= 2'b01;
      repeat (8) @(negedge clk);
      chk("stop request", low_voltage_request_line, 0);
      bus(0, `SVD_IRQ_OFS, 0, "stop status");
      bus(0, `SVD_CTRL_OFS, 32'h1, "stop flags");
      stop_mode <= 0;
      repeat (6) @(negedge clk);
      chk("request", low_voltage_request_line, 1);
      // Clear lands while the low event is still present: the set must win
      bus(1, `SVD_IRQ_OFS, 32'h20);
      bus(0, `SVD_IRQ_OFS, 32'h20, "set wins");
      bus(1, `SVD_CTRL_OFS, 0);
      repeat (4) @(negedge clk);
      chk("off request", low_voltage_request_line, 0);
      bus(0, `SVD_CTRL_OFS, 0, "off flags");
      bus(0, `SVD_IRQ_OFS, 32'h20, "sticky");
      s_axi_wstrb <= 4'h0;
      bus(1, `SVD_CTRL_OFS, 32'h1);
      s_axi_wstrb <= 4'hf;
      bus(0, `SVD_CTRL_OFS, 0, "strobe off");
      bus(1, `SVD_IMR_OFS, 32'h20);
      @(negedge clk);
      chk("irq unmasked", irq_q, 1);
      $display("stop and disable test done");
      @(posedge clk);
      reset <= 1;
      repeat (3) @(posedge clk);
      reset <= 0;
      bus(0, `SVD_IRQ_OFS, 0, "reset status");
      bus(0, `SVD_CTRL_OFS, 0, "reset control");
      bus(0, `SVD_IMR_OFS, 0, "reset mask");
      @(negedge clk);
      chk("reset irq", irq_q, 0);
      $display("mid-run reset test done");
      wrap_up();
   end
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      wrap_up();
   end
endmodule
`default_nettype wire
